// ===== src/sit_pkg.sv
// shared constants, register map and bus event carrier for the sensor target port
package sit_pkg;
  // clocking and timing
  localparam int CLK_HZ = 20_000_000;
  localparam int SCL_MAX_HZ = 1_000_000;
  localparam int MIN_SAMPLES = 8;
  localparam int TIMEOUT_MS = 200;
  localparam int STREAM_MS = 10;
  localparam int STRETCH_NS = 100;
  localparam int TIMEOUT_CYC = TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int STREAM_CYC = STREAM_MS * (CLK_HZ / 1000);
  localparam int STRETCH_RAW = (STRETCH_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int STRETCH_CYC = (STRETCH_RAW < 1) ? 1 : STRETCH_RAW;

  // register map, 8-bit addresses of 16-bit words
  localparam logic [7:0] REG_SYS_STATUS = 8'h10;
  localparam logic [7:0] REG_SYS_CONTROL = 8'h30;
  localparam logic [7:0] REG_BUS_ADDR = 8'hB1;

  // field positions
  localparam int ST_RESET_BIT = 0;
  localparam int ST_WINDOW_BIT = 1;
  localparam int ST_EVENT_BIT = 2;
  localparam int CTL_ACK_RESET_BIT = 0;
  localparam int CTL_EVENT_MODE_BIT = 1;

  // reset values and special bytes
  localparam logic CTL_EVENT_MODE_RST = 1'b0;
  localparam logic [6:0] ADDR_DEFAULT = 7'h44;
  localparam logic [7:0] INVALID_BYTE = 8'hEE;
  localparam logic [7:0] FORCE_CMD = 8'hFF;

  typedef struct packed {
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
  } sit_bus_ev_t;
endpackage

// ===== src/sit_sync.sv
// two-flop synchroniser for pin levels
`timescale 1ns/1ps
module sit_sync import sit_pkg::*; #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // levels
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  if (W < 1) begin : g_bad_w
    $error("sit_sync: W must be at least 1");
  end

  // reset to low so nothing is taken as released before the pins are really seen
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else if (ce_i) begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;
endmodule

// ===== src/sit_bus_events.sv
// edge, start and stop detection on the synchronised serial lines
`timescale 1ns/1ps
module sit_bus_events import sit_pkg::*; (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // synchronised lines
  input wire logic scl_i,
  input wire logic sda_i,
  // events
  output sit_bus_ev_t ev_o
);
  logic scl_q;
  logic sda_q;
  sit_bus_ev_t ev_d;
  sit_bus_ev_t ev_q;

  assign ev_d.scl = scl_i;
  assign ev_d.sda = sda_i;
  assign ev_d.scl_rise = scl_i & ~scl_q;
  assign ev_d.scl_fall = ~scl_i & scl_q;
  assign ev_d.start = scl_i & scl_q & sda_q & ~sda_i;
  assign ev_d.stop = scl_i & scl_q & ~sda_q & sda_i;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      ev_q <= '0;
    end else if (ce_i) begin
      scl_q <= scl_i;
      sda_q <= sda_i;
      ev_q <= ev_d;
    end
  end

  assign ev_o = ev_q;
endmodule

// ===== src/sit_target.sv
// serial target port with boot-time clear input, ready windows and register file
`timescale 1ns/1ps
module sit_target import sit_pkg::*; #(
  parameter int TIMEOUT_CYCLES = TIMEOUT_CYC,
  parameter int STREAM_CYCLES = STREAM_CYC
) (
  // clock, reset, enable
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // serial clock
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_o,
  // serial data
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // clear / ready pin
  input wire logic clear_or_window_pin_i,
  output logic clear_or_window_pin_o,
  output logic clear_or_window_pin_oe_o,
  // device side
  input wire logic event_i,
  output logic booted_o,
  output logic window_open_o
);
  localparam int CNT_MAX = (TIMEOUT_CYCLES > STREAM_CYCLES) ? TIMEOUT_CYCLES : STREAM_CYCLES;
  localparam int CNT_W = $clog2(CNT_MAX + 1);

  if (TIMEOUT_CYCLES < 1 || STREAM_CYCLES < 1 || STRETCH_CYC > 15) begin : g_bad_cnt
    $error("sit_target: counts out of range");
  end
  // sampling needs several system clocks per serial clock period
  if (CLK_HZ / SCL_MAX_HZ < MIN_SAMPLES) begin : g_bad_rate
    $error("sit_target: system clock too slow for the serial clock");
  end

  typedef enum logic [2:0] {S_IDLE, S_ADDR, S_REG, S_WDATA, S_ACK, S_RDATA, S_HACK} sit_state_t;

  function automatic logic addr_match(input logic [6:0] a, input logic [6:0] prim);
    addr_match = (a == prim) || (a == {prim[6:1], ~prim[0]});
  endfunction

  logic [2:0] pins_s;
  sit_bus_ev_t ev;
  sit_state_t state_q;
  sit_state_t nxt_q;
  logic [3:0] cnt_q;
  logic [7:0] sh_q;
  logic [7:0] tx_q;
  logic [7:0] reg_q;
  logic hi_q;
  logic [7:0] wlow_q;
  logic sda_oe_q;
  logic scl_oe_q;
  logic [3:0] str_q;
  logic win_q;
  logic served_q;
  logic pend_q;
  logic force_q;
  logic rst_flag_q;
  logic evmode_q;
  logic [6:0] prim_q;
  logic booted_q;
  logic cow_oe_q;
  logic [CNT_W-1:0] wcnt_q;
  logic [CNT_W-1:0] scnt_q;

  sit_sync #(
    .W(3)
  ) u_sync (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .d_i({clear_or_window_pin_i, sda_i, scl_i}),
    .q_o(pins_s)
  );

  sit_bus_events u_ev (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .scl_i(pins_s[0]),
    .sda_i(pins_s[1]),
    .ev_o(ev)
  );

  // byte level decode
  wire pin_high = pins_s[2];
  wire byte_done = ev.scl_fall && (cnt_q == 4'd8);
  wire addr_hit = addr_match(sh_q[7:1], prim_q);
  wire addr_done = (state_q == S_ADDR) && byte_done;
  wire reg_done = (state_q == S_REG) && byte_done;
  wire wdat_done = (state_q == S_WDATA) && byte_done;
  wire wr_commit = wdat_done && hi_q;
  wire [15:0] wr_word = {sh_q, wlow_q};
  wire force_hit = reg_done && (sh_q == FORCE_CMD);
  wire ack_fall = (state_q == S_ACK) && ev.scl_fall;
  wire to_read = ack_fall && (nxt_q == S_RDATA);
  wire host_ack = (state_q == S_HACK) && ev.scl_rise && !ev.sda;
  wire ack_bit = wr_commit && (reg_q == REG_SYS_CONTROL) && wr_word[CTL_ACK_RESET_BIT];
  wire sit_state_t byte_nxt = (state_q != S_ADDR) ? S_WDATA : (sh_q[0] ? S_RDATA : S_REG);

  // read path
  logic [15:0] status_w;
  logic [15:0] control_w;
  always_comb begin
    status_w = '0;
    status_w[ST_RESET_BIT] = rst_flag_q;
    status_w[ST_WINDOW_BIT] = win_q;
    status_w[ST_EVENT_BIT] = pend_q;
    control_w = '0;
    control_w[CTL_EVENT_MODE_BIT] = evmode_q;
  end
  wire rd_valid = (reg_q == REG_SYS_STATUS) || (reg_q == REG_SYS_CONTROL) ||
                  (reg_q == REG_BUS_ADDR);
  wire [15:0] rd_word = (reg_q == REG_SYS_STATUS) ? status_w :
                        (reg_q == REG_SYS_CONTROL) ? control_w : {9'h000, prim_q};
  wire [7:0] rd_byte = (!win_q || !rd_valid) ? INVALID_BYTE :
                       (hi_q ? rd_word[15:8] : rd_word[7:0]);

  // window control
  wire stream_due = !evmode_q && (scnt_q == CNT_W'(STREAM_CYCLES - 1));
  wire open_now = booted_q && !win_q && (force_q || stream_due || (evmode_q && pend_q));
  wire timeout = win_q && (wcnt_q == CNT_W'(TIMEOUT_CYCLES - 1));
  wire close_now = win_q && ((ev.stop && served_q) || timeout || force_hit);

  // serial protocol engine
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      state_q <= S_IDLE;
      nxt_q <= S_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      tx_q <= 8'h00;
      sda_oe_q <= 1'b0;
    end else if (ce_i) begin
      if (!booted_q || ev.stop) begin
        state_q <= S_IDLE;
        sda_oe_q <= 1'b0;
      end else if (ev.start) begin
        state_q <= S_ADDR;
        cnt_q <= 4'h0;
        sda_oe_q <= 1'b0;
      end else begin
        unique case (state_q)
          S_IDLE: begin
          end
          S_ADDR, S_REG, S_WDATA: begin
            if (ev.scl_rise && cnt_q != 4'd8) begin
              sh_q <= {sh_q[6:0], ev.sda};
              cnt_q <= cnt_q + 4'h1;
            end
            if (byte_done) begin
              cnt_q <= 4'h0;
              if (addr_done && !addr_hit) begin
                state_q <= S_IDLE;
              end else begin
                state_q <= S_ACK;
                nxt_q <= byte_nxt;
                sda_oe_q <= 1'b1;
              end
            end
          end
          S_ACK: begin
            if (ev.scl_fall) begin
              state_q <= nxt_q;
              tx_q <= {rd_byte[6:0], 1'b0};
              sda_oe_q <= (nxt_q == S_RDATA) && !rd_byte[7];
              cnt_q <= (nxt_q == S_RDATA) ? 4'h1 : 4'h0; // read msb is already out
            end
          end
          S_RDATA: begin
            if (ev.scl_fall) begin
              if (cnt_q == 4'd8) begin
                state_q <= S_HACK;
                sda_oe_q <= 1'b0;
              end else begin
                sda_oe_q <= !tx_q[7];
                tx_q <= {tx_q[6:0], 1'b0};
                cnt_q <= cnt_q + 4'h1;
              end
            end
          end
          S_HACK: begin
            if (ev.scl_rise) begin
              state_q <= ev.sda ? S_IDLE : S_ACK;
              nxt_q <= S_RDATA;
            end
          end
          default: state_q <= S_IDLE;
        endcase
      end
    end
  end

  // clock stretch while the next read byte is fetched
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      str_q <= 4'h0;
      scl_oe_q <= 1'b0;
    end else if (ce_i) begin
      if (to_read) begin
        str_q <= 4'(STRETCH_CYC);
        scl_oe_q <= 1'b1;
      end else if (str_q != 4'h0) begin
        str_q <= str_q - 4'h1;
        scl_oe_q <= (str_q != 4'h1);
      end
    end
  end

  // register pointer, auto-increment per word
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      reg_q <= 8'h00;
      hi_q <= 1'b0;
      wlow_q <= 8'h00;
    end else if (ce_i) begin
      if (reg_done) begin
        reg_q <= sh_q;
        hi_q <= 1'b0;
      end else if (addr_done) begin
        hi_q <= 1'b0;
      end else if (wdat_done) begin
        wlow_q <= sh_q;
        hi_q <= !hi_q;
        reg_q <= hi_q ? reg_q + 8'h01 : reg_q;
      end else if (host_ack) begin
        hi_q <= !hi_q;
        reg_q <= hi_q ? reg_q + 8'h01 : reg_q;
      end
    end
  end

  // writable registers and reset flag
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      rst_flag_q <= 1'b1;
      evmode_q <= CTL_EVENT_MODE_RST;
      prim_q <= ADDR_DEFAULT;
    end else if (ce_i) begin
      if (ack_bit) begin
        rst_flag_q <= 1'b0;
      end
      if (wr_commit && reg_q == REG_SYS_CONTROL) begin
        evmode_q <= wr_word[CTL_EVENT_MODE_BIT];
      end
      if (wr_commit && reg_q == REG_BUS_ADDR) begin
        prim_q <= wr_word[6:0];
      end
    end
  end

  // boot hold on the clear pin, then ready windows
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      booted_q <= 1'b0;
      cow_oe_q <= 1'b1;
    end else if (ce_i) begin
      booted_q <= booted_q || pin_high;
      cow_oe_q <= booted_q && win_q;
    end
  end

  // events that arrive while being consumed are kept: set wins
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      win_q <= 1'b0;
      served_q <= 1'b0;
      pend_q <= 1'b0;
      force_q <= 1'b0;
      wcnt_q <= '0;
      scnt_q <= '0;
    end else if (ce_i) begin
      pend_q <= event_i || (pend_q && !(open_now && evmode_q));
      force_q <= (force_hit && !win_q) || (force_q && !open_now);
      if (open_now) begin
        win_q <= 1'b1;
      end else if (close_now) begin
        win_q <= 1'b0;
      end
      served_q <= (served_q || (addr_done && addr_hit && win_q)) && !close_now;
      wcnt_q <= win_q && !close_now ? wcnt_q + CNT_W'(1) : '0;
      scnt_q <= (!win_q && !stream_due && booted_q) ? scnt_q + CNT_W'(1) : '0;
    end
  end

  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign clear_or_window_pin_o = 1'b0;
  assign scl_oe_o = scl_oe_q;
  assign sda_oe_o = sda_oe_q;
  assign clear_or_window_pin_oe_o = cow_oe_q;
  assign booted_o = booted_q;
  assign window_open_o = win_q;

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);

  chk_boot_pin_drive: assert property ($rose(rst_n_i) |-> clear_or_window_pin_oe_o)
    else $error("pin not driven low at reset release");
  chk_held_no_answer: assert property (!booted_q |-> !sda_oe_o && !scl_oe_o)
    else $error("bus answered while held in reset");
  chk_release_boots: assert property (ce_i && !booted_q && pin_high |=> booted_q)
    else $error("no boot after pin release");
  chk_flag_at_boot: assert property (!booted_q |-> status_w[ST_RESET_BIT])
    else $error("reset flag missing after reset");
  chk_ack_clears: assert property (ce_i && ack_bit |=> !rst_flag_q)
    else $error("reset acknowledge did not clear flag");
  chk_ready_follows: assert property (ce_i && booted_q |=> cow_oe_q == $past(win_q))
    else $error("ready pin does not follow window");
  chk_stop_closes: assert property (ce_i && ev.stop && served_q && win_q |=> !win_q)
    else $error("stop did not close window");
  chk_only_match_ack: assert property (ce_i && addr_done && booted_q && !ev.stop && !ev.start
    |=> sda_oe_q == addr_hit)
    else $error("address acknowledge mismatch");
  chk_invalid_byte: assert property (ce_i && to_read && booted_q && !win_q
    |-> rd_byte == INVALID_BYTE)
    else $error("closed window read not 0xEE");
  chk_stretch_ends: assert property ($rose(scl_oe_o) |-> ##[1:16] !scl_oe_o)
    else $error("clock stretch too long");
endmodule

// ===== verification/sit_host_model.sv
// behavioural serial bus controller that faces the target port
`timescale 1ns/1ps
module sit_host_model (
  // clock
  input wire logic clk_sys_i,
  // wire levels
  input wire logic scl_i,
  input wire logic sda_i,
  // pull-downs, high = line pulled low
  output logic scl_oe_o,
  output logic sda_oe_o
);
  // 200 ns phases give a 400 ns serial clock, 2.5 MHz, above the 1 MHz ceiling
  localparam int PHASE = 4;

  initial begin
    scl_oe_o = 1'b0;
    sda_oe_o = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask

  // a stretched clock is waited out, bounded so a stuck line cannot hang us
  task automatic rise_scl();
    int guard;
    guard = 0;
    scl_oe_o <= 1'b0;
    @(posedge clk_sys_i);
    while (scl_i !== 1'b1 && guard < 100) begin
      @(posedge clk_sys_i);
      guard++;
    end
    wait_clk(PHASE - 1);
  endtask

  // entered with the clock low; data changes one cycle after the fall
  task automatic bit_io(input logic b, output logic r);
    sda_oe_o <= !b;
    wait_clk(PHASE - 1);
    rise_scl();
    r = sda_i;
    scl_oe_o <= 1'b1;
    @(posedge clk_sys_i);
  endtask

  // also serves as repeated start when the clock is low
  task automatic start();
    sda_oe_o <= 1'b0;
    wait_clk(PHASE);
    rise_scl();
    sda_oe_o <= 1'b1;
    wait_clk(PHASE);
    scl_oe_o <= 1'b1;
    @(posedge clk_sys_i);
  endtask

  task automatic stop();
    sda_oe_o <= 1'b1;
    wait_clk(PHASE);
    rise_scl();
    sda_oe_o <= 1'b0;
    wait_clk(PHASE);
  endtask

  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], r);
    end
    bit_io(1'b1, r);
    ack = (r === 1'b0);
  endtask

  // last byte is answered with a release, the others with a pull
  task automatic rd_byte(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, b[i]);
    end
    bit_io(last, r);
  endtask
endmodule

// ===== verification/sit_target_bench.sv
// self-checking bench for the sensor target port
`timescale 1ns/1ps
module sit_target_bench;
  import sit_pkg::*;
  logic clk_sys_i, rst_n_i, event_i, pin_hold, ce;
  logic scl_oe, sda_oe, pin_oe, h_scl_oe, h_sda_oe, booted, win_open;
  wire logic scl_w, sda_w, pin_w;
  int errors, tests_run;
  int stretch_n = 0;

  // every line has a pull-up, so a released line reads high
  assign scl_w = !(scl_oe | h_scl_oe);
  assign sda_w = !(sda_oe | h_sda_oe);
  assign pin_w = !(pin_oe | pin_hold);

  sit_target #(.TIMEOUT_CYCLES(5000), .STREAM_CYCLES(100)) dut_u (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ce_i(ce),
    .scl_i(scl_w), .scl_o(), .scl_oe_o(scl_oe),
    .sda_i(sda_w), .sda_o(), .sda_oe_o(sda_oe),
    .clear_or_window_pin_i(pin_w), .clear_or_window_pin_o(),
    .clear_or_window_pin_oe_o(pin_oe),
    .event_i(event_i), .booted_o(booted), .window_open_o(win_open)
  );

  sit_host_model host_u (
    .clk_sys_i(clk_sys_i), .scl_i(scl_w), .sda_i(sda_w),
    .scl_oe_o(h_scl_oe), .sda_oe_o(h_sda_oe)
  );

  initial begin
    clk_sys_i = 1'b0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end

  // cycles in which the target holds the serial clock low
  always @(posedge clk_sys_i) begin
    if (scl_oe === 1'b1) begin
      stretch_n++;
    end
  end

  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'b1) begin
      errors++;
      $display("wrong value at %0t ns: %s", $time, msg);
    end
  endtask

  task automatic wait_win(input int n, output logic seen);
    seen = 1'b0;
    for (int i = 0; i < n && seen !== 1'b1; i++) begin
      @(posedge clk_sys_i);
      seen = (win_open === 1'b1);
    end
  endtask

  task automatic pulse_event();
    event_i <= 1'b1;
    @(posedge clk_sys_i);
    event_i <= 1'b0;
  endtask

  // leaves the bus busy so the caller chooses stop or repeated start
  task automatic rd_word(input logic [6:0] a, input logic [7:0] r, output logic [15:0] w,
                         output logic ok);
    logic a1, a2, a3;
    host_u.start();
    host_u.wr_byte({a, 1'b0}, a1);
    host_u.wr_byte(r, a2);
    host_u.start();
    host_u.wr_byte({a, 1'b1}, a3);
    host_u.rd_byte(1'b0, w[7:0]);
    host_u.rd_byte(1'b1, w[15:8]);
    ok = a1 & a2 & a3;
  endtask

  // low byte goes first on the wire
  task automatic wr_word(input logic [6:0] a, input logic [7:0] r, input logic [15:0] d,
                         output logic ok);
    logic a1, a2, a3, a4;
    host_u.start();
    host_u.wr_byte({a, 1'b0}, a1);
    host_u.wr_byte(r, a2);
    host_u.wr_byte(d[7:0], a3);
    host_u.wr_byte(d[15:8], a4);
    ok = a1 & a2 & a3 & a4;
  endtask

  task automatic t_boot();
    logic ack;
    repeat (2) @(posedge clk_sys_i);
    chk(pin_oe === 1'b0, "pin not released after reset");
    repeat (20) @(posedge clk_sys_i);
    chk(booted === 1'b0, "booted while pin held low");
    host_u.start();
    host_u.wr_byte({ADDR_DEFAULT, 1'b0}, ack);
    host_u.stop();
    chk(ack === 1'b0, "answered while held in reset");
    pin_hold <= 1'b0;
    repeat (8) @(posedge clk_sys_i);
    chk(booted === 1'b1, "no boot after pin release");
    $display("test boot finished");
  endtask

  task automatic t_flag();
    logic seen, ok;
    logic [15:0] w;
    wait_win(400, seen);
    chk(seen === 1'b1, "no streaming window");
    repeat (2) @(posedge clk_sys_i);
    chk(pin_oe === 1'b1, "ready pin not pulled in window");
    rd_word(ADDR_DEFAULT, REG_SYS_STATUS, w, ok);
    chk(ok === 1'b1, "default address not acked");
    chk(stretch_n == 2 * STRETCH_CYC, "no stretch before each read byte");
    chk(w[ST_RESET_BIT] === 1'b1 && w[ST_WINDOW_BIT] === 1'b1, "status after reset");
    // ack the reset and switch to event windows in one word
    wr_word(ADDR_DEFAULT, REG_SYS_CONTROL, 16'h0003, ok);
    rd_word(ADDR_DEFAULT, REG_SYS_STATUS, w, ok);
    chk(w[ST_RESET_BIT] === 1'b0, "reset flag not cleared");
    host_u.stop();
    repeat (8) @(posedge clk_sys_i);
    chk(win_open === 1'b0 && pin_oe === 1'b0, "window kept after stop");
    $display("test reset flag finished");
  endtask

  task automatic t_event();
    logic seen, ok;
    logic [15:0] w;
    repeat (300) @(posedge clk_sys_i);
    chk(win_open === 1'b0, "window without event");
    rd_word(ADDR_DEFAULT, REG_SYS_STATUS, w, ok);
    host_u.stop();
    chk(w === {2{INVALID_BYTE}}, "read outside window");
    pulse_event();
    wait_win(20, seen);
    chk(seen === 1'b1, "event did not open window");
    rd_word(ADDR_DEFAULT, 8'h20, w, ok);
    chk(w === {2{INVALID_BYTE}}, "unmapped read");
    wr_word(ADDR_DEFAULT, REG_BUS_ADDR, 16'h0031, ok);
    chk(ok === 1'b1, "address write not acked");
    host_u.stop();
    $display("test event mode finished");
  endtask

  task automatic t_addr();
    logic seen, ok, ack;
    logic [15:0] w;
    pulse_event();
    wait_win(20, seen);
    host_u.start();
    host_u.wr_byte({ADDR_DEFAULT, 1'b0}, ack);
    chk(ack === 1'b0, "old address still answered");
    rd_word(7'h31, REG_BUS_ADDR, w, ok);
    chk(ok === 1'b1 && w[6:0] === 7'h31, "new primary address");
    // alias touched here for a debug check only
    host_u.start();
    host_u.wr_byte({7'h30, 1'b0}, ack);
    chk(ack === 1'b1, "alias not acked");
    host_u.stop();
    $display("test address finished");
  endtask

  // register address 0xFF toggles the window, bus left idle afterwards
  task automatic force_cmd();
    logic a1, a2;
    host_u.start();
    host_u.wr_byte({7'h31, 1'b0}, a1);
    host_u.wr_byte(FORCE_CMD, a2);
    host_u.stop();
    repeat (8) @(posedge clk_sys_i);
  endtask

  // a low clock enable must freeze the window timer as well
  task automatic t_force();
    force_cmd();
    chk(win_open === 1'b1 && pin_oe === 1'b1, "forced window did not open");
    force_cmd();
    chk(win_open === 1'b0 && pin_oe === 1'b0, "forced close kept window");
    force_cmd();
    ce <= 1'b0;
    repeat (300) @(posedge clk_sys_i);
    ce <= 1'b1;
    repeat (4700) @(posedge clk_sys_i);
    chk(win_open === 1'b1, "window timer ran while disabled");
    repeat (600) @(posedge clk_sys_i);
    chk(win_open === 1'b0 && pin_oe === 1'b0, "window did not time out");
    $display("test force and timeout finished");
  endtask

  initial begin
    rst_n_i = 1'b0;
    ce = 1'b1;
    event_i = 1'b0;
    pin_hold = 1'b1;
    errors = 0;
    tests_run = 0;
    repeat (16) @(posedge clk_sys_i);
    chk(pin_oe === 1'b1, "pin not pulled in reset");
    rst_n_i <= 1'b1;
    t_boot();
    t_flag();
    t_event();
    t_addr();
    t_force();
    wrap_up();
  end

  // the whole run needs well under a third of this
  initial begin
    repeat (60000) @(posedge clk_sys_i);
    errors++;
    wrap_up();
  end
endmodule
